// *** src/tsr_readout.v ***
// Conversion scheduler and serial shift-out of a read-only temperature sensor.
// Assumes chip select and serial clock arrive from an external controller, asynchronous;
// the measured value arrives on i_temp_meas from the analog front end, on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defines.vh"
module tsr_readout #(
  parameter CONV_CYCLES = `TSR_CONV_CYCLES,
  parameter IDLE_CYCLES = `TSR_IDLE_CYCLES
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_cs_n,
  input wire i_sck,
  input wire [`TSR_TEMP_BITS-1:0] i_temp_meas,
  output reg o_so,
  output reg o_so_oe,
  output reg o_analog_shdn,
  output reg o_conv_active,
  output reg o_conv_done
);
  localparam CW = `TSR_TIMER_BITS;
  localparam CNT_W = `TSR_CNT_BITS;

  // Last timer value of each phase; the cut to CW bits is deliberate,
  // both counts must stay below 2^CW
  localparam [31:0] CONV_LAST_W = CONV_CYCLES - 1;
  localparam [31:0] IDLE_LAST_W = IDLE_CYCLES - 1;
  localparam [CW-1:0] CONV_LAST = CONV_LAST_W[CW-1:0];
  localparam [CW-1:0] IDLE_LAST = IDLE_LAST_W[CW-1:0];

  // Schedule states
  localparam [1:0] ST_CONV = `TSR_ST_CONV;
  localparam [1:0] ST_IDLE = `TSR_ST_IDLE;
  localparam [1:0] ST_SHDN = `TSR_ST_SHDN;

  wire cs_n_s;
  wire sck_s;
  wire cs_fall;
  wire cs_rise;
  wire sck_fall;
  wire conv_end;
  reg cs_n_d_reg;
  reg sck_d_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CW-1:0] timer_reg;
  reg [CW-1:0] timer_next;
  reg [`TSR_TEMP_BITS-1:0] result_reg;
  reg [`TSR_TEMP_BITS-1:0] result_next;
  reg [`TSR_WORD_BITS-1:0] shift_reg;
  reg [`TSR_WORD_BITS-1:0] shift_next;
  reg [CNT_W-1:0] bit_cnt_reg;
  reg [CNT_W-1:0] bit_cnt_next;
  reg shdn_next;
  reg active_next;
  reg so_next;
  reg so_oe_next;

  // Select idles high and the serial clock low, so reset values match
  // the idle levels and no false edge follows reset
  tsr_sync u_sync_cs (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_rst_val(1'b1),
    .i_async(i_cs_n),
    .o_sync(cs_n_s)
  );
  tsr_sync u_sync_sck (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_rst_val(1'b0),
    .i_async(i_sck),
    .o_sync(sck_s)
  );

  // Edge detection on the synchronised pins
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      cs_n_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
    end else begin
      cs_n_d_reg <= cs_n_s;
      sck_d_reg <= sck_s;
    end
  end

  assign cs_fall = cs_n_d_reg & ~cs_n_s;
  assign cs_rise = ~cs_n_d_reg & cs_n_s;
  assign sck_fall = sck_d_reg & ~sck_s;
  // A conversion that ends as select drops is not stored
  assign conv_end = (state_reg == ST_CONV) && (timer_reg == CONV_LAST) && cs_n_s;

  // Conversion schedule, next state
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    result_next = result_reg;
    shdn_next = o_analog_shdn;
    active_next = o_conv_active;
    if (conv_end) begin
      result_next = i_temp_meas;
    end
    if (cs_fall) begin
      state_next = ST_SHDN;
      timer_next = {CW{1'b0}};
      shdn_next = 1'b1;
      active_next = 1'b0;
    end else begin
      case (state_reg)
        ST_CONV: begin
          if (timer_reg == CONV_LAST) begin
            state_next = ST_IDLE;
            timer_next = {CW{1'b0}};
            active_next = 1'b0;
          end else begin
            timer_next = timer_reg + 1'b1;
          end
        end
        ST_IDLE: begin
          if (timer_reg == IDLE_LAST) begin
            state_next = ST_CONV;
            timer_next = {CW{1'b0}};
            active_next = 1'b1;
          end else begin
            timer_next = timer_reg + 1'b1;
          end
        end
        ST_SHDN: begin
          if (cs_rise) begin
            state_next = ST_CONV;
            timer_next = {CW{1'b0}};
            shdn_next = 1'b0;
            active_next = 1'b1;
          end
        end
        default: begin
          state_next = ST_CONV;
          timer_next = {CW{1'b0}};
        end
      endcase
    end
  end

  // Conversion schedule, state registers
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= ST_CONV;
      timer_reg <= {CW{1'b0}};
      result_reg <= `TSR_RESET_TEMP;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      result_reg <= result_next;
    end
  end

  // Conversion schedule, analog side flags
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_analog_shdn <= 1'b0;
      o_conv_active <= 1'b1;
      o_conv_done <= 1'b0;
    end else begin
      o_analog_shdn <= shdn_next;
      o_conv_active <= active_next;
      o_conv_done <= conv_end;
    end
  end

  // Serial shift-out, next state
  always @* begin
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    so_next = o_so;
    so_oe_next = o_so_oe;
    if (cs_fall) begin
      // Completed result only; an aborted conversion never reaches result_reg
      shift_next = {result_reg, 1'b0, {`TSR_HIZ_BITS{1'b0}}};
      so_next = result_reg[`TSR_TEMP_BITS-1];
      so_oe_next = 1'b1;
      bit_cnt_next = {CNT_W{1'b0}};
    end else if (cs_n_s) begin
      so_oe_next = 1'b0;
      so_next = 1'b0;
      bit_cnt_next = {CNT_W{1'b0}};
    end else if (sck_fall && (bit_cnt_reg != `TSR_CNT_MAX)) begin
      shift_next = {shift_reg[`TSR_WORD_BITS-2:0], 1'b0};
      so_next = shift_reg[`TSR_WORD_BITS-2];
      bit_cnt_next = bit_cnt_reg + 1'b1;
      // Bit 2 still driven low; bits 1..0 and anything past the word released
      so_oe_next = (bit_cnt_reg < `TSR_DRIVEN_FALLS);
    end
  end

  // Serial shift-out, shift register and counter
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      shift_reg <= {`TSR_WORD_BITS{1'b0}};
      bit_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Serial shift-out, pin registers
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so <= so_next;
      o_so_oe <= so_oe_next;
    end
  end
endmodule // tsr_readout
`default_nettype wire

// *** src/tsr_defines.vh ***
// Constants for the temperature sensor serial readout block.
// Assumes inclusion by bare name from design files of the same block.
// Notes on behaviour
// - While chip select is high, conversions repeat on schedule with an idle phase between.
// - Chip select falling aborts any conversion and enters analog shutdown.
// - Chip select falling loads shift register with last completed result only.
// - Serial output advances one bit on each falling serial clock edge.
// - Sixteen-bit word goes out sign bit first, then MSB toward LSB.
// - Host may end a read after any bit count; device tolerates it.
// - Each conversion takes nominally 0.25 s of measurement.
// - After a conversion with chip select high, idle for 0.25 s.
// - With chip select high, conversion starts every 0.5 s.
// - Word is sign plus 12-bit temperature, confirmation bit, two high-impedance bits.
// - Temperature is two's complement; negative values set the sign bit.
// - Chip select rising releases serial output to high impedance.
// - Bits 15..3 carry temperature, bit 2 is zero, bits 1..0 undriven.
// - One temperature step equals 0.0625 degrees Celsius.
// - After reset, reads return zero until the first conversion completes.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH
`define TSR_CLK_HZ 25000000
`define TSR_CONV_TIME_MS 250
`define TSR_IDLE_TIME_MS 250
`define TSR_CONV_CYCLES (`TSR_CLK_HZ / 1000 * `TSR_CONV_TIME_MS)
`define TSR_IDLE_CYCLES (`TSR_CLK_HZ / 1000 * `TSR_IDLE_TIME_MS)
`define TSR_WORD_BITS 16
`define TSR_TEMP_BITS 13
`define TSR_ZERO_BIT 2
`define TSR_HIZ_BITS 2
`define TSR_TIMER_BITS 24
`define TSR_CNT_BITS 5
`define TSR_CNT_MAX 5'h1f
`define TSR_DRIVEN_FALLS 5'h0d
`define TSR_RESET_TEMP 13'h0000
`define TSR_ST_CONV 2'h0
`define TSR_ST_IDLE 2'h1
`define TSR_ST_SHDN 2'h2
`endif

// *** src/tsr_sync.v ***
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tsr_sync (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_rst_val,
  input wire i_async,
  output reg o_sync
);
  reg meta_reg;
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      meta_reg <= i_rst_val;
      o_sync <= i_rst_val;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // tsr_sync
`default_nettype wire

// *** verification/tsr_readout_checker.sv ***
// Port assertions for the sensor readout.
// Assumes bind onto tsr_readout; pins change just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_checker (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_analog_shdn,
  input wire logic o_conv_active,
  input wire logic o_conv_done
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  chk_fall_loads: assert property ($fell(i_cs_n) |-> ##3 o_so_oe && o_analog_shdn)
    else $error("no load after select fall");
  chk_rise_hiz: assert property ($rose(i_cs_n) |-> ##3 !o_so_oe)
    else $error("output driven after select rise");
  chk_rise_restart: assert property ($rose(i_cs_n) |-> ##3 !o_analog_shdn && o_conv_active)
    else $error("no restart after select rise");
  chk_high_quiet: assert property (i_cs_n [*4] |-> !o_so_oe)
    else $error("output driven while deselected");
  chk_oe_in_shdn: assert property (o_so_oe |-> o_analog_shdn)
    else $error("read outside shutdown");
  chk_shdn_idle: assert property (o_analog_shdn |-> !o_conv_active && !o_conv_done)
    else $error("conversion during shutdown");
  chk_done_pulse: assert property (o_conv_done |=> !o_conv_done)
    else $error("done longer than one cycle");
  chk_shift_cause: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so)
    |-> $past(i_sck, 4) && !$past(i_sck, 3))
    else $error("bit changed without clock fall");
endmodule // tsr_readout_checker
`default_nettype wire

// *** verification/tsr_host.sv ***
// Host model: drives select and serial clock, samples serial data.
// Assumes the design samples its pins on i_clk_sys; SCK period 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
  input wire logic i_clk_sys,
  input wire logic i_so,
  input wire logic i_so_oe,
  output logic o_cs_n = 1'b1,
  output logic o_sck = 1'b0
);
  task rd(input int n, output logic [15:0] d, output logic [15:0] e);
    d = 16'h0000;
    e = 16'h0000;
    @(posedge i_clk_sys) o_cs_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    for (int i = 15; i > 15 - n; i--) begin
      d[i] = i_so;
      e[i] = i_so_oe;
      o_sck <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
    end
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
  endtask
endmodule // tsr_host
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the sensor readout.
// Assumes tsr_host drives select and clock; short conversion counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [12:0] temp = 13'h1abc;
  wire cs_n, sck, so, oe, shdn, act, done;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] d, e;
  always #20 i_clk_sys = ~i_clk_sys;
  tsr_readout #(.CONV_CYCLES(100), .IDLE_CYCLES(100)) DUT (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_cs_n(cs_n), .i_sck(sck), .i_temp_meas(temp), .o_so(so),
    .o_so_oe(oe), .o_analog_shdn(shdn), .o_conv_active(act), .o_conv_done(done));
  tsr_host host (.i_clk_sys(i_clk_sys), .i_so(so), .i_so_oe(oe), .o_cs_n(cs_n), .o_sck(sck));
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task end_sim;
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wait_done(output int c);
    c = 0;
    do begin
      @(negedge i_clk_sys);
      c++;
    end while (done !== 1'b1 && c < 1000);
  endtask
  task t_period;
    int c;
    wait_done(c);
    wait_done(c);
    chk("period", 16'd200, c[15:0]);
  endtask
  task t_full;
    int c;
    wait_done(c);
    host.rd(16, d, e);
    chk("word", {temp, 3'b000}, d & 16'hfffc);
    chk("oe mask", 16'hfffc, e);
  endtask
  task t_abort;
    int c;
    temp <= 13'h0123;
    repeat (20) @(posedge i_clk_sys);
    host.rd(5, d, e);
    chk("old word", {13'h1abc, 3'b000} & 16'hf800, d);
    wait_done(c);
    // 100 conversion (done register on the last edge) + 3 sync + 1 sample, less host tail of 8
    chk("fresh wait", 16'd97 - 16'd1, c[15:0]);
    host.rd(16, d, e);
    chk("new word", {13'h0123, 3'b000}, d & 16'hfffc);
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    host.rd(16, d, e);
    chk("reset word", 16'h0000, d);
    t_period();
    t_full();
    t_abort();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_total++;
    end_sim();
  end
endmodule // testbench
bind tsr_readout tsr_readout_checker chk_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe),
  .o_analog_shdn(o_analog_shdn), .o_conv_active(o_conv_active), .o_conv_done(o_conv_done));
`default_nettype wire
